//--- design/nv_access_defs.svh
`ifndef NV_ACCESS_DEFS_SVH
`define NV_ACCESS_DEFS_SVH

// Nonvolatile array geometry
`define NV_MEM_BYTES 256
`define NV_ADDR_W 8

// Device register selects on the core link
`define NV_REG_ADDR 2'h0
`define NV_REG_DATA 2'h1
`define NV_REG_CTRL 2'h2

// Control register bit positions
`define NV_CTRL_READ 0
`define NV_CTRL_PROG 1
`define NV_CTRL_ARM 2

// Core stall lengths and arm window, in clk cycles
`define NV_READ_STALL 3'h4
`define NV_WRITE_STALL 3'h2
`define NV_ARM_WINDOW 3'h4

// Write timing in calibrated oscillator cycles
`define NV_WRITE_TICKS 13600
`define NV_OSC_HZ 4000000
`define NV_CLK_HZ 100000000
`define NV_OSC_DIV (`NV_CLK_HZ / `NV_OSC_HZ)

// Value left in a byte whose write was aborted
`define NV_INVALID_BYTE 8'hFF

// Controller register byte offsets on the bus
`define NV_WB_ADDR 8'h00
`define NV_WB_WDATA 8'h04
`define NV_WB_CMD 8'h08
`define NV_WB_RDATA 8'h0C
`define NV_WB_STATUS 8'h10
`define NV_WB_IRQ_STAT 8'h14
`define NV_WB_IRQ_MASK 8'h18

// Command and interrupt bits
`define NV_CMD_READ 0
`define NV_CMD_WRITE 1
`define NV_IRQ_READ 0
`define NV_IRQ_WRITE 1
`define NV_IRQ_W 2

`endif

//--- design/nv_access_pkg.sv
package nv_access_pkg;

  typedef logic [1:0] reg_sel_t;
  typedef logic [7:0] nv_byte_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_POLL  = 4'h1,
    ST_CHECK = 4'h3,
    ST_ADDR  = 4'h2,
    ST_DATA  = 4'h6,
    ST_ARM   = 4'h7,
    ST_PROG  = 4'h5,
    ST_HOLD  = 4'h4,
    ST_TRIG  = 4'hA,
    ST_FETCH = 4'hC,
    ST_TAKE  = 4'h8
  } core_state_t;

endpackage

//--- design/nv_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface nv_link_if;
  nv_access_pkg::reg_sel_t regSel;
  logic regWrite;
  logic regRead;
  nv_access_pkg::nv_byte_t regWdata;
  nv_access_pkg::nv_byte_t regRdata;
  logic stall;

  modport device (
    input regSel,
    input regWrite,
    input regRead,
    input regWdata,
    output regRdata,
    output stall
  );

  modport core (
    output regSel,
    output regWrite,
    output regRead,
    output regWdata,
    input regRdata,
    input stall
  );
endinterface

`default_nettype wire

//--- design/nv_osc_tick.sv
`timescale 1ns/1ps
`default_nettype none

// Stands in for the calibrated RC oscillator as a clock enable
module nv_osc_tick #(
  parameter int DIV = 25
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  // Enable pulse
  output logic tick
);
  logic [15:0] divCnt_q;
  wire atEnd = divCnt_q == 16'(DIV - 1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_q <= 16'h0000;
    end else if (!run || atEnd) begin
      divCnt_q <= 16'h0000;
    end else begin
      divCnt_q <= divCnt_q + 16'h0001;
    end
  end

  assign tick = run && atEnd;
endmodule // nv_osc_tick

`default_nettype wire

//--- design/nv_access_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "nv_access_defs.svh"
// Function
// RULE1 - 256 bytes, each byte accessed alone
// RULE2 - Address, data, control reachable as registers
// RULE3 - Read stalls core four cycles
// RULE4 - Program strobe stalls core two cycles
// RULE5 - Core arms, then programs within four cycles
// RULE6 - Unused arm lapses, no write happens
// RULE7 - Hardware clears program strobe when done
// RULE8 - Write timed by oscillator cycle count
// RULE9 - Write lasts 13600 oscillator cycles
// RULE10 - Blackout aborts write, byte invalid
// RULE11 - Read strobe bit 0 reads addressed byte
// RULE12 - During write, no reads, address frozen
// RULE13 - Core polls program strobe before reading
// RULE14 - Core keeps write sequence uninterrupted
// RULE15 - Core waits for self-program completion
// RULE16 - Read strobe self-clears, data holds byte
// RULE17 - Arm clears on expiry or write start

module nv_access_device #(
  parameter int WRITE_TICKS = `NV_WRITE_TICKS,
  parameter int OSC_DIV = `NV_OSC_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Core register link
  nv_link_if.device link,
  // Supply monitor
  input wire logic blackoutReset,
  // Status
  output logic writeBusy
);

  logic [7:0] memArray [0:`NV_MEM_BYTES-1]; // RULE1

  logic [`NV_ADDR_W-1:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] wrData_q;
  logic [7:0] rdata_q;
  logic arm_q;
  logic [2:0] armCnt_q;
  logic prog_q;
  logic [2:0] stallCnt_q;
  // 16 bits limits WRITE_TICKS to 65536
  logic [15:0] tickCnt_q;
  logic boSync1_q;
  logic boSync2_q;
  logic boSync3_q;
  logic blackout_q;
  logic oscTick;

  // Register decode
  wire selAddr = link.regSel == `NV_REG_ADDR;
  wire selData = link.regSel == `NV_REG_DATA;
  wire selCtrl = link.regSel == `NV_REG_CTRL;
  wire ctrlWrite = link.regWrite && selCtrl; // RULE2
  wire addrWrite = link.regWrite && selAddr;
  wire dataWrite = link.regWrite && selData;
  wire wArm = link.regWdata[`NV_CTRL_ARM];
  wire wProg = link.regWdata[`NV_CTRL_PROG];
  wire wRead = link.regWdata[`NV_CTRL_READ];

  // Arming needs a zero program bit in the same write
  wire armReq = ctrlWrite && wArm && !wProg && !prog_q;
  // Program only inside a live arm window, never during blackout
  wire progReq = ctrlWrite && wProg && arm_q && !prog_q && !blackout_q; // RULE5
  wire readReq = ctrlWrite && wRead && !wProg && !prog_q; // RULE12
  wire armExpire = arm_q && armCnt_q == 3'h1; // RULE6
  wire writeDone = prog_q && oscTick && tickCnt_q == 16'(WRITE_TICKS - 1); // RULE9
  // Abort outranks a completion landing in the same cycle
  wire writeAbort = prog_q && blackout_q; // RULE10

  // Read strobe reads back clear, as it self-clears at once
  logic [7:0] ctrlView;
  always_comb begin
    ctrlView = 8'h00;
    ctrlView[`NV_CTRL_ARM] = arm_q;
    ctrlView[`NV_CTRL_PROG] = prog_q; // RULE7
  end

  wire [7:0] readMux = selAddr ? addr_q :
                       selData ? data_q :
                       selCtrl ? ctrlView : 8'h00;

  // Oscillator runs only while a write is in progress
  nv_osc_tick #(
    .DIV(OSC_DIV)
  ) u_nv_osc_tick (
    .clk(clk),
    .reset_n(reset_n),
    .run(prog_q),
    .tick(oscTick)
  );

  // Blackout arrives from an analog monitor, so it is synchronised
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boSync1_q <= 1'b0;
      boSync2_q <= 1'b0;
      boSync3_q <= 1'b0;
      blackout_q <= 1'b0;
    end else begin
      boSync1_q <= blackoutReset;
      boSync2_q <= boSync1_q;
      boSync3_q <= boSync2_q;
      if (boSync2_q == boSync3_q) begin
        blackout_q <= boSync3_q;
      end
    end
  end

  // Address is frozen while a write runs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= 8'h00;
    end else if (addrWrite && !prog_q) begin // RULE12
      addr_q <= link.regWdata;
    end
  end

  // Read trigger loads the addressed byte into data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= 8'h00;
    end else if (readReq) begin
      data_q <= memArray[addr_q]; // RULE11 RULE16
    end else if (dataWrite) begin
      data_q <= link.regWdata;
    end
  end

  // Arm window, reloaded by a fresh arm write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arm_q <= 1'b0;
      armCnt_q <= 3'h0;
    end else if (progReq || blackout_q) begin
      arm_q <= 1'b0; // RULE17
      armCnt_q <= 3'h0;
    end else if (armReq) begin
      arm_q <= 1'b1;
      armCnt_q <= `NV_ARM_WINDOW;
    end else if (armExpire) begin
      arm_q <= 1'b0; // RULE6 RULE17
      armCnt_q <= 3'h0;
    end else if (arm_q) begin
      armCnt_q <= armCnt_q - 3'h1;
    end
  end

  // Write in progress and its oscillator cycle count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_q <= 1'b0;
      tickCnt_q <= 16'h0000;
      wrData_q <= 8'h00;
    end else if (progReq) begin
      prog_q <= 1'b1;
      tickCnt_q <= 16'h0000;
      wrData_q <= data_q;
    end else if (writeAbort || writeDone) begin
      prog_q <= 1'b0; // RULE7 RULE10
      tickCnt_q <= 16'h0000;
    end else if (oscTick) begin
      tickCnt_q <= tickCnt_q + 16'h0001; // RULE8
    end
  end

  // Array holds no reset; an aborted byte is left invalid
  always_ff @(posedge clk) begin
    if (writeAbort) begin
      memArray[addr_q] <= `NV_INVALID_BYTE; // RULE10
    end else if (writeDone) begin
      memArray[addr_q] <= wrData_q;
    end
  end

  // Stall length set by whichever access caused it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stallCnt_q <= 3'h0;
    end else if (readReq) begin
      stallCnt_q <= `NV_READ_STALL; // RULE3
    end else if (progReq) begin
      stallCnt_q <= `NV_WRITE_STALL; // RULE4
    end else if (stallCnt_q != 3'h0) begin
      stallCnt_q <= stallCnt_q - 3'h1;
    end
  end

  // Register value reaches the link a cycle after the read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (link.regRead) begin
      rdata_q <= readMux;
    end
  end

  assign link.regRdata = rdata_q;
  assign link.stall = stallCnt_q != 3'h0;
  assign writeBusy = prog_q;
endmodule // nv_access_device

`default_nettype wire

//--- design/nv_core_host.sv
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "nv_access_defs.svh"

module nv_core_host (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  // System
  input wire logic selfProgBusy,
  output logic irq,
  // Device link
  nv_link_if.core link
);

  nv_access_pkg::core_state_t state_q;
  nv_access_pkg::core_state_t state_d;
  logic ack_q;
  logic [31:0] dat_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic opWrite_q;
  logic post_q;
  logic [`NV_IRQ_W-1:0] irqStat_q;
  logic [`NV_IRQ_W-1:0] irqMask_q;

  wire wbReq = wb_cyc_i && wb_stb_i;
  wire wbWr = wbReq && ack_q && wb_we_i && wb_sel_i[0];
  wire wrAddr = wbWr && wb_adr_i == `NV_WB_ADDR;
  wire wrWdata = wbWr && wb_adr_i == `NV_WB_WDATA;
  wire wrCmd = wbWr && wb_adr_i == `NV_WB_CMD;
  wire wrStat = wbWr && wb_adr_i == `NV_WB_IRQ_STAT;
  wire wrMask = wbWr && wb_adr_i == `NV_WB_IRQ_MASK;
  wire idle = state_q == nv_access_pkg::ST_IDLE;
  // Commands while busy are dropped; status shows busy
  wire startRd = wrCmd && idle && wb_dat_i[`NV_CMD_READ];
  wire startWr = wrCmd && idle && wb_dat_i[`NV_CMD_WRITE] && !wb_dat_i[`NV_CMD_READ];
  wire progBusy = link.regRdata[`NV_CTRL_PROG];
  wire checkNow = state_q == nv_access_pkg::ST_CHECK;
  wire readDone = state_q == nv_access_pkg::ST_TAKE;
  wire writeDoneEv = checkNow && !progBusy && post_q;
  wire [`NV_IRQ_W-1:0] irqSet = {writeDoneEv, readDone};

  wire [31:0] readMux = (wb_adr_i == `NV_WB_ADDR) ? {24'h000000, addr_q} :
                        (wb_adr_i == `NV_WB_WDATA) ? {24'h000000, wdata_q} :
                        (wb_adr_i == `NV_WB_RDATA) ? {24'h000000, rdata_q} :
                        (wb_adr_i == `NV_WB_STATUS) ? {31'h00000000, !idle} :
                        (wb_adr_i == `NV_WB_IRQ_STAT) ? {30'h00000000, irqStat_q} :
                        (wb_adr_i == `NV_WB_IRQ_MASK) ? {30'h00000000, irqMask_q} : 32'h00000000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= wbReq && !ack_q;
      if (wbReq && !ack_q) begin
        dat_q <= readMux;
      end
    end
  end

  // The whole sequence runs here, so nothing can split it
  always_comb begin
    state_d = state_q;
    case (state_q)
      nv_access_pkg::ST_IDLE: begin
        if (startRd || startWr) begin
          state_d = nv_access_pkg::ST_POLL;
        end
      end
      nv_access_pkg::ST_POLL: begin
        if (!link.stall) begin
          state_d = nv_access_pkg::ST_CHECK;
        end
      end
      nv_access_pkg::ST_CHECK: begin
        if (progBusy || (opWrite_q && !post_q && selfProgBusy)) begin // RULE13 RULE15
          state_d = nv_access_pkg::ST_POLL;
        end else if (post_q) begin
          state_d = nv_access_pkg::ST_IDLE;
        end else begin
          state_d = nv_access_pkg::ST_ADDR;
        end
      end
      nv_access_pkg::ST_ADDR: begin
        state_d = opWrite_q ? nv_access_pkg::ST_DATA : nv_access_pkg::ST_TRIG;
      end
      nv_access_pkg::ST_DATA: state_d = nv_access_pkg::ST_ARM;
      nv_access_pkg::ST_ARM: state_d = nv_access_pkg::ST_PROG; // RULE5 RULE14
      nv_access_pkg::ST_PROG: state_d = nv_access_pkg::ST_HOLD;
      nv_access_pkg::ST_TRIG: state_d = nv_access_pkg::ST_HOLD;
      nv_access_pkg::ST_HOLD: begin
        if (!link.stall) begin
          state_d = opWrite_q ? nv_access_pkg::ST_POLL : nv_access_pkg::ST_FETCH;
        end
      end
      nv_access_pkg::ST_FETCH: state_d = nv_access_pkg::ST_TAKE;
      nv_access_pkg::ST_TAKE: state_d = nv_access_pkg::ST_IDLE;
      default: state_d = nv_access_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= nv_access_pkg::ST_IDLE;
      opWrite_q <= 1'b0;
      post_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (startRd || startWr) begin
        opWrite_q <= startWr;
        post_q <= 1'b0;
      end else if (state_q == nv_access_pkg::ST_PROG) begin
        post_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      irqMask_q <= '0;
      irqStat_q <= '0;
    end else begin
      if (wrAddr && idle) begin
        addr_q <= wb_dat_i[7:0];
      end
      if (wrWdata && idle) begin
        wdata_q <= wb_dat_i[7:0];
      end
      if (readDone) begin
        rdata_q <= link.regRdata;
      end
      if (wrMask) begin
        irqMask_q <= wb_dat_i[`NV_IRQ_W-1:0];
      end
      // Set beats a same-cycle clear
      irqStat_q <= (irqStat_q & ~(wrStat ? wb_dat_i[`NV_IRQ_W-1:0] : '0)) | irqSet;
    end
  end

  // Link strobes follow the state directly
  wire inPoll = state_q == nv_access_pkg::ST_POLL;
  wire inFetch = state_q == nv_access_pkg::ST_FETCH;
  wire inAddr = state_q == nv_access_pkg::ST_ADDR;
  wire inData = state_q == nv_access_pkg::ST_DATA;
  wire inArm = state_q == nv_access_pkg::ST_ARM;
  wire inProg = state_q == nv_access_pkg::ST_PROG;
  wire inTrig = state_q == nv_access_pkg::ST_TRIG;

  assign link.regRead = (inPoll && !link.stall) || inFetch;
  assign link.regWrite = inAddr || inData || inArm || inProg || inTrig;
  assign link.regSel = inAddr ? `NV_REG_ADDR : (inData || inFetch) ? `NV_REG_DATA : `NV_REG_CTRL;
  assign link.regWdata = inAddr ? addr_q :
                         inData ? wdata_q :
                         inArm ? 8'(1 << `NV_CTRL_ARM) :
                         inProg ? 8'(1 << `NV_CTRL_PROG) :
                         inTrig ? 8'(1 << `NV_CTRL_READ) : 8'h00;

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq = |(irqStat_q & irqMask_q);
endmodule // nv_core_host

`default_nettype wire

//--- dv/nv_access_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module nv_access_monitor #(
  parameter int WRITE_TICKS = 4,
  parameter int OSC_DIV = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Core link
  input wire nv_access_pkg::reg_sel_t regSel,
  input wire logic regWrite,
  input wire logic regRead,
  input wire nv_access_pkg::nv_byte_t regWdata,
  input wire nv_access_pkg::nv_byte_t regRdata,
  input wire logic stall,
  // Device side
  input wire logic blackoutReset,
  input wire logic writeBusy
);
  // Oscillator restarts with each write; still allow one tick either way
  localparam int LO = (WRITE_TICKS - 1) * OSC_DIV;
  localparam int HI = (WRITE_TICKS + 1) * OSC_DIV + 2;

  logic [15:0] busyCnt_q;
  wire ctrlWr = regWrite && regSel == 2'h2;
  wire armWr = ctrlWr && regWdata == 8'h04 && !writeBusy && !blackoutReset;
  wire progWr = ctrlWr && regWdata == 8'h02 && !blackoutReset;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      busyCnt_q <= 16'h0;
    else
      busyCnt_q <= writeBusy ? busyCnt_q + 16'h1 : 16'h0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence armThenProg;
    armWr ##1 progWr;
  endsequence

  read_stall_a: assert property (ctrlWr && regWdata == 8'h01 && !writeBusy |=> stall [*4] ##1 !stall)
    else $error("read stall length wrong");
  stall_quiet_a: assert property (stall |-> !regWrite && !regRead)
    else $error("core strobed during stall");
  write_stall_a: assert property ($rose(writeBusy) |-> stall ##1 stall ##1 !stall)
    else $error("write stall length wrong");
  arm_prog_a: assert property (armThenProg |=> writeBusy)
    else $error("armed program did not start");
  prog_cause_a: assert property ($rose(writeBusy) |-> $past(progWr) && $past(armWr, 2))
    else $error("write started without arm and program");
  busy_len_a: assert property ($fell(writeBusy) && !blackoutReset |-> busyCnt_q >= LO && busyCnt_q <= HI)
    else $error("write duration out of range");
  blackout_abort_a: assert property (blackoutReset [*7] |-> !writeBusy)
    else $error("blackout did not abort write");
  rdata_hold_a: assert property (!regRead |=> $stable(regRdata))
    else $error("read data changed without read");
  ctrl_view_a: assert property (regRead && regSel == 2'h2 |=> regRdata[1] == $past(writeBusy) && !regRdata[0])
    else $error("control view wrong");
endmodule // nv_access_monitor

`default_nettype wire

//--- dv/tb_eeprom_cpu_access.sv
`timescale 1ns/1ps
`default_nettype none
`include "nv_access_defs.svh"

module tb_eeprom_cpu_access;
  localparam int TICKS = 8;
  localparam int DIV = 2;

  logic clk;
  logic reset_n;
  logic [7:0] adr;
  logic [31:0] datW;
  logic [31:0] datR;
  logic we;
  logic [3:0] sel;
  logic cyc;
  logic stb;
  logic ack;
  logic selfProgBusy;
  logic irq;
  logic blackoutReset;
  logic writeBusy;
  logic busy2;
  int error_cnt;
  int compares;
  int nBusy;
  int n;

  nv_link_if lnk();
  nv_link_if lnk2();

  nv_core_host u_nv_core_host (.clk(clk), .reset_n(reset_n), .wb_adr_i(adr), .wb_dat_i(datW),
    .wb_dat_o(datR), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .selfProgBusy(selfProgBusy), .irq(irq), .link(lnk));
  nv_access_device #(.WRITE_TICKS(TICKS), .OSC_DIV(DIV)) u_nv_access_device (.clk(clk),
    .reset_n(reset_n), .link(lnk), .blackoutReset(blackoutReset), .writeBusy(writeBusy));
  // Second device driven raw, so core-side misuse can be staged
  nv_access_device #(.WRITE_TICKS(TICKS), .OSC_DIV(DIV)) u_nv_access_device_b (.clk(clk),
    .reset_n(reset_n), .link(lnk2), .blackoutReset(1'b0), .writeBusy(busy2));
  nv_access_monitor #(.WRITE_TICKS(TICKS), .OSC_DIV(DIV)) u_nv_access_monitor (.clk(clk),
    .reset_n(reset_n), .regSel(lnk.regSel), .regWrite(lnk.regWrite), .regRead(lnk.regRead),
    .regWdata(lnk.regWdata), .regRdata(lnk.regRdata), .stall(lnk.stall),
    .blackoutReset(blackoutReset), .writeBusy(writeBusy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      $display("[FAIL] bus ack expected 1 seen 0");
      report_and_stop;
    end
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask

  // Polls status; the write op only ends once the strobe reads clear
  task automatic wait_idle;
    logic [31:0] q;
    int k;
    k = 0;
    do begin
      wb(1'b0, `NV_WB_STATUS, 32'h0, q);
      k++;
    end while (q[0] !== 1'b0 && k < 300);
    if (k >= 300) begin
      error_cnt++;
      $display("[FAIL] idle status expected 0 seen 1");
      report_and_stop;
    end
  endtask

  task automatic dw(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    lnk2.regSel <= s;
    lnk2.regWdata <= d;
    lnk2.regWrite <= 1'b1;
    @(posedge clk);
    lnk2.regWrite <= 1'b0;
  endtask

  task automatic dr(input logic [1:0] s, input logic [7:0] exp, input string what);
    @(posedge clk);
    lnk2.regSel <= s;
    lnk2.regRead <= 1'b1;
    @(posedge clk);
    lnk2.regRead <= 1'b0;
    @(negedge clk);
    check(what, {24'h0, exp}, {24'h0, lnk2.regRdata});
  endtask

  // Counts stall and busy cycles over a window longer than any write
  task automatic watch(input int exp, input string what);
    int k;
    k = 0;
    nBusy = 0;
    repeat (30) begin
      @(negedge clk);
      k += int'(lnk2.stall === 1'b1);
      nBusy += int'(busy2 === 1'b1);
    end
    check(what, exp, k);
  endtask

  initial begin
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    datW = 32'h0;
    sel = 4'hF;
    selfProgBusy = 1'b0;
    blackoutReset = 1'b0;
    lnk2.regSel = 2'h0;
    lnk2.regWrite = 1'b0;
    lnk2.regRead = 1'b0;
    lnk2.regWdata = 8'h00;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rdc(`NV_WB_STATUS, 32'h0, "status");
    rdc(8'h1C, 32'h0, "unmapped");
    dw(2'h0, 8'h20);
    dw(2'h2, 8'h04);
    dr(2'h2, 8'h04, "arm bit");
    repeat (6) @(posedge clk);
    dr(2'h2, 8'h00, "arm lapsed");
    dw(2'h2, 8'h02);
    watch(0, "lapsed stall");
    check("lapsed busy", 32'h0, nBusy);
    dw(2'h1, 8'h3C);
    dw(2'h2, 8'h04);
    dw(2'h2, 8'h02);
    watch(2, "write stall");
    check("write time", TICKS * DIV, nBusy);
    dw(2'h1, 8'hC3);
    dw(2'h2, 8'h04);
    dw(2'h2, 8'h02);
    repeat (3) @(posedge clk);
    dw(2'h0, 8'h10);
    dr(2'h2, 8'h02, "prog busy");
    dw(2'h2, 8'h01);
    watch(0, "read in write");
    dr(2'h2, 8'h00, "prog clear");
    dr(2'h0, 8'h20, "addr frozen");
    dw(2'h1, 8'h00);
    dw(2'h2, 8'h01);
    watch(4, "read stall");
    dr(2'h1, 8'hC3, "read byte");
    dr(2'h2, 8'h00, "strobe clear");
    wr(`NV_WB_IRQ_MASK, 32'h3);
    wr(`NV_WB_ADDR, 32'h0);
    wr(`NV_WB_WDATA, 32'hA5);
    wr(`NV_WB_CMD, 32'h2);
    wr(`NV_WB_ADDR, 32'h77);
    wait_idle;
    check("irq set", 32'h1, irq);
    rdc(`NV_WB_ADDR, 32'h0, "addr held while busy");
    rdc(`NV_WB_IRQ_STAT, 32'h2, "irq stat");
    wr(`NV_WB_IRQ_STAT, 32'h2);
    @(negedge clk);
    check("irq clear", 32'h0, irq);
    wr(`NV_WB_ADDR, 32'hFF);
    wr(`NV_WB_WDATA, 32'h5A);
    wr(`NV_WB_CMD, 32'h2);
    wait_idle;
    wr(`NV_WB_IRQ_MASK, 32'h0);
    wr(`NV_WB_ADDR, 32'h0);
    wr(`NV_WB_CMD, 32'h1);
    wait_idle;
    rdc(`NV_WB_RDATA, 32'hA5, "byte 0");
    check("irq masked", 32'h0, irq);
    wr(`NV_WB_ADDR, 32'hFF);
    wr(`NV_WB_CMD, 32'h3);
    wait_idle;
    rdc(`NV_WB_RDATA, 32'h5A, "byte 255");
    selfProgBusy <= 1'b1;
    wr(`NV_WB_ADDR, 32'h40);
    wr(`NV_WB_WDATA, 32'h11);
    wr(`NV_WB_CMD, 32'h2);
    repeat (12) @(posedge clk);
    check("self prog hold", 32'h0, writeBusy);
    selfProgBusy <= 1'b0;
    wait_idle;
    wr(`NV_WB_CMD, 32'h2);
    for (n = 0; n < 50 && writeBusy !== 1'b1; n++) @(posedge clk);
    check("write began", 32'h1, writeBusy);
    blackoutReset <= 1'b1;
    repeat (10) @(posedge clk);
    blackoutReset <= 1'b0;
    repeat (5) @(posedge clk);
    wait_idle;
    wr(`NV_WB_CMD, 32'h1);
    wait_idle;
    rdc(`NV_WB_RDATA, 32'hFF, "aborted byte");
    report_and_stop;
  end
endmodule // tb_eeprom_cpu_access

`default_nettype wire
